/* tws_pkg.sv */
// Shared constants and types for the two-wire serial framing block
package tws_pkg;

  // ==========================================================================
  // Clock and timing
  localparam longint unsigned CLK_HZ = 20000000;
  localparam longint unsigned TWR_MS = 5;
  localparam int unsigned TWR_CYCLES_DEF = int'((TWR_MS * CLK_HZ) / 1000);

  // ==========================================================================
  // Word framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int unsigned RW_BIT = 0;
  localparam int unsigned LINK_SYNC_W = 5;
  localparam int unsigned SYS_SYNC_W = 4;

  // ==========================================================================
  // Receive buffer
  localparam int unsigned FIFO_WIDTH = 9;
  localparam int unsigned FIFO_DEPTH = 16;

  // ==========================================================================
  // Link-side framing states
  typedef enum logic [2:0] {
    L_IDLE,
    L_RECV,
    L_ACK,
    L_SEND,
    L_MACK,
    L_WAIT
  } tws_link_state_t;

endpackage

/* tws_fifo_if.sv */
// Carrier between the framer and its receive buffer
`timescale 1ns/1ps
interface tws_fifo_if #(
  parameter int WIDTH = 8
);
  logic w_valid;
  logic w_ready;
  logic [WIDTH-1:0] w_data;
  logic r_valid;
  logic r_ready;
  logic [WIDTH-1:0] r_data;

  modport fifo (input w_valid, w_data, r_ready, output w_ready, r_valid, r_data);
  modport prod (output w_valid, w_data, input w_ready);
  modport cons (input r_valid, r_data, output r_ready);
endinterface

/* tws_sync.sv */
// Two-flop synchroniser for levels, toggles and gray-coded pointers
`timescale 1ns/1ps
module tws_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk,
  // Asynchronous inputs and synchronised outputs
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // ==========================================================================
  // No reset here so the reset itself can pass through this stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

/* tws_fifo.sv */
// Dual-clock FIFO with gray pointers and a registered read word
`timescale 1ns/1ps
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Write domain
  input wire logic wclk,
  input wire logic wrst,
  // Read domain
  input wire logic rclk,
  input wire logic rrst,
  // Both handshakes
  tws_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin;
  logic [AW:0] rbin;
  logic [AW:0] wgray;
  logic [AW:0] rgray;
  logic [AW:0] wgray_r;
  logic [AW:0] rgray_w;
  logic [WIDTH-1:0] rword;
  logic rvalid;

  wire [AW:0] next_wbin = wbin + 1'b1;
  wire [AW:0] next_rbin = rbin + 1'b1;
  wire full = (wgray == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
  wire empty = (rgray == wgray_r);
  wire do_write = f.w_valid & ~full;
  wire do_load = ~empty & (~rvalid | f.r_ready);

  assign f.w_ready = ~full;
  assign f.r_valid = rvalid;
  assign f.r_data = rword;

  // ==========================================================================
  // Write side
  always_ff @(posedge wclk) begin
    if (wrst) begin
      wbin <= '0;
      wgray <= '0;
    end else if (do_write) begin
      wbin <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
  end

  always_ff @(posedge wclk) begin
    if (do_write) begin
      mem[wbin[AW-1:0]] <= f.w_data;
    end
  end

  // ==========================================================================
  // Read side: the output word is a register, refilled when taken
  always_ff @(posedge rclk) begin
    if (rrst) begin
      rbin <= '0;
      rgray <= '0;
      rvalid <= 1'b0;
      rword <= '0;
    end else if (do_load) begin
      rbin <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
      rvalid <= 1'b1;
      rword <= mem[rbin[AW-1:0]];
    end else if (f.r_ready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Pointer crossings
  tws_sync #(.WIDTH(AW + 1)) u_w2r (.clk(rclk), .d(wgray), .q(wgray_r));
  tws_sync #(.WIDTH(AW + 1)) u_r2w (.clk(wclk), .d(rgray), .q(rgray_w));
endmodule

/* tws_framer.sv */
// Two-wire serial device framing: start, stop, bytes, acknowledge, write cycle
`timescale 1ns/1ps
// ============================================================================
// Overview of operation
// - Data on the data line changes only while the clock is low.
// - Data-line edges during clock high are start or stop, never data.
// - Falling data with clock high is a start; command reception begins.
// - Rising data with clock high is a stop; the transaction ends.
// - A stop ending a read puts the device into standby.
// - Every word moves as eight bits, one per clock.
// - The device pulls the data line low on the ninth clock to acknowledge.
// - Written bits are sampled on clock rise, read bits launched on fall.
// - The device only pulls low; the pull-up supplies the high level.
// - A stop ending a write starts the self-timed write cycle.
module tws_framer
  import tws_pkg::*;
#(
  parameter int unsigned TWR_CYCLES = TWR_CYCLES_DEF
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link sampling clock
  input wire logic link_clk,
  // Two-wire pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Received words
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_valid,
  input wire logic rx_ready,
  // Read data supply
  output logic tx_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  // Status
  output logic write_busy,
  output logic standby
);
  localparam int CW = $clog2(TWR_CYCLES + 1);

  // ==========================================================================
  // Crossing signals
  logic rst_l;
  logic busy_l;
  logic ack_s;
  logic scl_s;
  logic sda_s;
  logic tx_ack_tgl;
  logic tx_req_tgl;
  logic wr_ev_tgl;
  logic rd_ev_tgl;
  logic start_tgl;
  logic wr_ev_s;
  logic rd_ev_s;
  logic start_s;
  logic req_s;
  logic [7:0] tx_buf;

  tws_sync #(.WIDTH(LINK_SYNC_W)) u_link_sync (
    .clk(link_clk),
    .d({rst, write_busy, tx_ack_tgl, scl, sda_in}),
    .q({rst_l, busy_l, ack_s, scl_s, sda_s})
  );

  tws_sync #(.WIDTH(SYS_SYNC_W)) u_sys_sync (
    .clk(clk),
    .d({wr_ev_tgl, rd_ev_tgl, start_tgl, tx_req_tgl}),
    .q({wr_ev_s, rd_ev_s, start_s, req_s})
  );

  // ==========================================================================
  // Receive buffer between link and system clocks
  tws_fifo_if #(.WIDTH(FIFO_WIDTH)) fif ();

  tws_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk(link_clk),
    .wrst(rst_l),
    .rclk(clk),
    .rrst(rst),
    .f(fif.fifo)
  );

  assign rx_data = fif.r_data[7:0];
  assign rx_first = fif.r_data[8];
  assign rx_valid = fif.r_valid;
  assign fif.r_ready = rx_ready;

  // ==========================================================================
  // Link domain: pin history and condition decode
  tws_link_state_t state;
  tws_link_state_t next_state;
  logic scl_q;
  logic sda_q;
  logic ack_q;
  logic [3:0] bit_cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] tx_word;
  logic oe_l;
  logic next_oe;
  logic first;
  logic next_first;
  logic rd;
  logic next_rd;
  logic wrote;
  logic next_wrote;
  logic mack;
  logic next_mack;
  logic push;
  logic [FIFO_WIDTH-1:0] push_data;
  logic do_push;
  logic do_txreq;
  logic do_wrev;
  logic do_rdev;
  logic do_start;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire scl_high = scl_s & scl_q;
  wire start_det = scl_high & sda_q & ~sda_s;
  wire stop_det = scl_high & ~sda_q & sda_s;
  wire byte_done = (bit_cnt == BYTE_BITS);
  wire tx_arrive = ack_s ^ ack_q;
  wire cmd_refused = first & busy_l;

  // ==========================================================================
  // Link domain: framing decisions
  // Pin changes are applied only on a sampled clock fall, so the line is
  // stable across every high phase the host sees.
  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_shreg = shreg;
    next_oe = oe_l;
    next_first = first;
    next_rd = rd;
    next_wrote = wrote;
    next_mack = mack;
    do_push = 1'b0;
    do_txreq = 1'b0;
    do_wrev = 1'b0;
    do_rdev = 1'b0;
    do_start = 1'b0;
    if (start_det) begin
      next_state = L_RECV;
      next_cnt = 4'h0;
      next_oe = 1'b0;
      next_first = 1'b1;
      next_rd = 1'b0;
      next_wrote = 1'b0;
      do_start = 1'b1;
    end else if (stop_det) begin
      next_state = L_IDLE;
      next_oe = 1'b0;
      do_wrev = wrote & ~rd;
      do_rdev = rd;
    end else begin
      case (state)
        L_RECV: begin
          if (scl_rise && !byte_done) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (cmd_refused || !fif.w_ready) begin
              next_state = L_WAIT;
            end else begin
              next_oe = 1'b1;
              next_state = L_ACK;
              do_push = 1'b1;
              do_txreq = first & shreg[RW_BIT];
              if (first) begin
                next_rd = shreg[RW_BIT];
              end else begin
                next_wrote = 1'b1;
              end
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            next_first = 1'b0;
            if (rd) begin
              next_state = L_SEND;
              next_oe = ~tx_word[7];
              next_shreg = {tx_word[6:0], 1'b0};
              next_cnt = 4'h1;
              // Fetch ahead: a whole byte time for the supplier to answer
              do_txreq = 1'b1;
            end else begin
              next_state = L_RECV;
              next_oe = 1'b0;
              next_cnt = 4'h0;
            end
          end
        end
        L_SEND: begin
          if (scl_fall) begin
            if (byte_done) begin
              next_oe = 1'b0;
              next_state = L_MACK;
            end else begin
              next_oe = ~shreg[7];
              next_shreg = {shreg[6:0], 1'b0};
              next_cnt = bit_cnt + 4'h1;
            end
          end
        end
        L_MACK: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end else if (scl_fall) begin
            if (mack) begin
              next_state = L_SEND;
              next_oe = ~tx_word[7];
              next_shreg = {tx_word[6:0], 1'b0};
              next_cnt = 4'h1;
              do_txreq = 1'b1;
            end else begin
              next_state = L_WAIT;
            end
          end
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Link domain: registers
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      state <= L_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      oe_l <= 1'b0;
      first <= 1'b0;
      rd <= 1'b0;
      wrote <= 1'b0;
      mack <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_cnt;
      shreg <= next_shreg;
      oe_l <= next_oe;
      first <= next_first;
      rd <= next_rd;
      wrote <= next_wrote;
      mack <= next_mack;
    end
  end

  // Idle-high history, so a data line held low with the clock high at reset release reads as a start
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ack_q <= 1'b0;
      tx_word <= 8'hFF;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      ack_q <= ack_s;
      if (tx_arrive) begin
        tx_word <= tx_buf;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      push <= 1'b0;
      push_data <= '0;
      tx_req_tgl <= 1'b0;
      wr_ev_tgl <= 1'b0;
      rd_ev_tgl <= 1'b0;
      start_tgl <= 1'b0;
    end else begin
      push <= do_push;
      push_data <= {first, shreg};
      tx_req_tgl <= tx_req_tgl ^ do_txreq;
      wr_ev_tgl <= wr_ev_tgl ^ do_wrev;
      rd_ev_tgl <= rd_ev_tgl ^ do_rdev;
      start_tgl <= start_tgl ^ do_start;
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge link_clk) begin
    sda_out <= 1'b0;
  end

  assign sda_oe = oe_l;
  assign fif.w_valid = push;
  assign fif.w_data = push_data;

  // ==========================================================================
  // System domain: event edges from the link
  logic wr_ev_q;
  logic rd_ev_q;
  logic start_q;
  logic req_q;
  logic [CW-1:0] twr_cnt;

  wire wr_seen = wr_ev_s ^ wr_ev_q;
  wire rd_seen = rd_ev_s ^ rd_ev_q;
  wire start_seen = start_s ^ start_q;
  wire req_seen = req_s ^ req_q;
  wire tx_take = tx_req & tx_valid;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ev_q <= 1'b0;
      rd_ev_q <= 1'b0;
      start_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      wr_ev_q <= wr_ev_s;
      rd_ev_q <= rd_ev_s;
      start_q <= start_s;
      req_q <= req_s;
    end
  end

  // ==========================================================================
  // System domain: read data handshake
  // The word must arrive before the clock fall that sends it; a late word
  // leaves the previous one on the line.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_req <= 1'b0;
      tx_buf <= 8'hFF;
      tx_ack_tgl <= 1'b0;
    end else begin
      if (req_seen) begin
        tx_req <= 1'b1;
      end else if (tx_take) begin
        tx_req <= 1'b0;
      end
      if (tx_take) begin
        tx_buf <= tx_data;
        tx_ack_tgl <= ~tx_ack_tgl;
      end
    end
  end

  // ==========================================================================
  // System domain: write cycle timer and standby
  always_ff @(posedge clk) begin
    if (rst) begin
      write_busy <= 1'b0;
      twr_cnt <= '0;
    end else if (wr_seen) begin
      write_busy <= 1'b1;
      twr_cnt <= CW'(TWR_CYCLES - 1);
    end else if (write_busy) begin
      if (twr_cnt == '0) begin
        write_busy <= 1'b0;
      end else begin
        twr_cnt <= twr_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      standby <= 1'b0;
    end else if (rd_seen) begin
      standby <= 1'b1;
    end else if (start_seen) begin
      standby <= 1'b0;
    end
  end
endmodule

/* tws_chk.sv */
// Concurrent checks on the framer ports
`timescale 1ns/1ps
module tws_chk #(
  parameter int unsigned TWR_CYCLES = 50
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  // Pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Streams and status
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_req,
  input wire logic tx_valid,
  input wire logic write_busy,
  input wire logic standby
);
  // ==========================================================================
  // Write cycle length, counted so a short or long timer shows up when busy falls
  int unsigned busy_cnt;
  always_ff @(posedge clk) begin
    if (rst || !write_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  // ==========================================================================
  // Assertions
  a_pull_only: assert property (@(posedge link_clk) disable iff (rst)
    sda_oe |-> !sda_out) else $error("data line driven high");
  a_oe_clock_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl) else $error("data line moved with clock high");
  a_ack_span: assert property (@(posedge link_clk) disable iff (rst)
    $rose(sda_oe) |=> sda_oe [*3]) else $error("low pull too short");
  a_rx_hold: assert property (@(posedge clk) disable iff (rst)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("word lost");
  a_tx_drop: assert property (@(posedge clk) disable iff (rst)
    tx_req && tx_valid |=> !tx_req) else $error("read request kept");
  a_busy_len: assert property (@(posedge clk) disable iff (rst)
    $fell(write_busy) |-> busy_cnt == TWR_CYCLES) else $error("write cycle length");
  a_busy_idle: assert property (@(posedge clk) disable iff (rst)
    $rose(write_busy) |-> scl && sda_in) else $error("write cycle without stop");
  a_standby_idle: assert property (@(posedge clk) disable iff (rst)
    $rose(standby) |-> scl && sda_in && !write_busy) else $error("standby without stop");
endmodule

bind tws_framer tws_chk #(.TWR_CYCLES(TWR_CYCLES)) u_chk (.clk(clk), .rst(rst),
  .link_clk(link_clk), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_req(tx_req),
  .tx_valid(tx_valid), .write_busy(write_busy), .standby(standby));

/* tws_host.sv */
// Bus master model: drives the clock and pulls the data line low
`timescale 1ns/1ps
module tws_host #(
  parameter int Q = 250
) (
  // Pins
  output logic scl,
  output logic sda_lo,
  input wire logic sda
);
  // Clock stands high and data is released outside frames
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // ==========================================================================
  // Bus conditions
  task automatic start_c();
    #Q sda_lo = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop_c();
    #Q sda_lo = 1'b1;
    #Q scl = 1'b1;
    #Q sda_lo = 1'b0;
    #Q;
  endtask
  // ==========================================================================
  // Bits and words; data is set mid low phase, read mid high phase
  task automatic bit_x(input logic b, output logic r);
    #Q sda_lo = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r,
    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(m, a);
  endtask
endmodule

/* two_wire_serial_bit_framing_tb.sv */
// Self-checking bench for the two-wire framer against a host model
`timescale 1ns/1ps
module two_wire_serial_bit_framing_tb;
  localparam int unsigned TWR = 400;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic hold_rx = 1'b0;
  wire scl;
  wire sda_lo;
  wire sda_oe;
  // Pull-up: the line is low if any party pulls it
  wire sda = !(sda_lo || sda_oe);
  logic [7:0] rx_data, r, d, cmd, nb;
  logic rx_first, rx_valid, tx_req, write_busy, standby, a;
  int fails = 0;
  int check_count = 0;
  int seed = 28703;
  int n;
  logic [8:0] rxq[$];
  logic [7:0] txq[$];
  always #25 clk = !clk;
  always #24 link_clk = !link_clk;
  tws_framer #(.TWR_CYCLES(TWR)) DUT (.clk(clk), .rst(rst), .link_clk(link_clk),
    .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .rx_data(rx_data),
    .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_req(tx_req),
    .tx_valid(tx_valid), .tx_data(tx_data), .write_busy(write_busy), .standby(standby));
  tws_host u_host (.scl(scl), .sda_lo(sda_lo), .sda(sda));
  // ==========================================================================
  // Reporting
  task automatic fail(input string m);
    fails++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_w(input logic [8:0] g, input logic [8:0] e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_f(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bounded wait: 0 busy, 1 standby, 2 all words drained
  task automatic wait_sig(input int k, input logic v, input int lim);
    int i;
    logic s;
    for (i = 0; i < lim; i++) begin
      @(negedge clk);
      s = (k == 0) ? write_busy : (k == 1) ? standby : (rxq.size() == 0);
      if (s === v) break;
    end
    if (i == lim) begin
      fail("wait timed out");
      wrap_up();
    end
  endtask
  // ==========================================================================
  // Stream drivers and word monitor
  always @(posedge clk) begin
    rx_ready <= !hold_rx && (($random(seed) & 1) != 0);
    tx_valid <= 1'b0;
    if (tx_req === 1'b1 && tx_valid !== 1'b1) begin
      nb = 8'($random(seed));
      tx_valid <= 1'b1;
      tx_data <= nb;
      txq.push_back(nb);
    end
    if (!rst && rx_valid === 1'b1 && rx_ready) begin
      if (rxq.size() == 0) fail("stray word");
      else chk_w({rx_first, rx_data}, rxq.pop_front(), "rx word");
    end
  end
  initial begin
    #3000000;
    fail("run timed out");
    wrap_up();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    // Longer than two cycles: the link side needs its own synchronised reset
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    cmd = {7'($random(seed)), 1'b0};
    rxq.push_back({1'b1, cmd});
    u_host.start_c();
    u_host.xfer(cmd, 1'b1, r, a);
    chk_f(a, 1'b0, "cmd ack");
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      rxq.push_back({1'b0, d});
      u_host.xfer(d, 1'b1, r, a);
      chk_f(a, 1'b0, "data ack");
    end
    u_host.stop_c();
    wait_sig(0, 1'b1, 40);
    $display("test write done");
    @(negedge clk) hold_rx = 1'b1;
    n = 0;
    do begin
      u_host.start_c();
      u_host.xfer(cmd, 1'b1, r, a);
      if (n == 0) chk_f(a, 1'b1, "busy nack");
      if (a !== 1'b0) u_host.stop_c();
      n++;
    end while (a !== 1'b0 && n < 40);
    chk_f(a, 1'b0, "poll ack");
    rxq.push_back({1'b1, cmd});
    u_host.stop_c();
    @(negedge clk) hold_rx = 1'b0;
    repeat (20) @(negedge clk);
    chk_f(write_busy, 1'b0, "no cycle without data");
    $display("test polling done");
    cmd = {7'($random(seed)), 1'b1};
    rxq.push_back({1'b1, cmd});
    u_host.start_c();
    u_host.xfer(cmd, 1'b1, r, a);
    chk_f(a, 1'b0, "read cmd ack");
    for (int k = 0; k < 2; k++) begin
      u_host.xfer(8'hFF, k[0], r, a);
      chk_w({1'b0, r}, {1'b0, txq.pop_front()}, "read byte");
    end
    u_host.stop_c();
    wait_sig(1, 1'b1, 40);
    chk_f(write_busy, 1'b0, "read started write");
    $display("test read done");
    // Stalled consumer: fill the buffer until a byte is refused
    @(negedge clk) hold_rx = 1'b1;
    cmd = {7'($random(seed)), 1'b0};
    rxq.push_back({1'b1, cmd});
    u_host.start_c();
    u_host.xfer(cmd, 1'b1, r, a);
    chk_f(standby, 1'b0, "standby kept");
    n = 0;
    while (a !== 1'b1 && n < 24) begin
      d = 8'($random(seed));
      u_host.xfer(d, 1'b1, r, a);
      if (a === 1'b0) rxq.push_back({1'b0, d});
      n++;
    end
    chk_f(a, 1'b1, "full nack");
    u_host.stop_c();
    @(negedge clk) hold_rx = 1'b0;
    wait_sig(2, 1'b1, 400);
    wait_sig(0, 1'b0, 600);
    repeat (10) @(negedge clk);
    chk_f(rxq.size() == 0, 1'b1, "words left");
    $display("test fill done");
    wrap_up();
  end
endmodule
